/* verilog/fhsr_pkg.sv */
package fhsr_pkg;

  // apb geometry: register index = paddr[11:2]
  localparam int          APB_AW           = 12;
  localparam int          IDX_W            = 10;
  localparam logic [9:0]  IDX_MAIN_STATUS  = 10'h3F4;
  localparam logic [9:0]  IDX_DATA_PORT    = 10'h3F5;
  localparam logic [9:0]  IDX_DIGITAL_IN   = 10'h3F7;
  localparam logic [9:0]  IDX_FORCE_CHG    = 10'h018;
  localparam logic [9:0]  IDX_RATE_SHADOW  = 10'h019;
  localparam logic [9:0]  IDX_DRIVE_CFG    = 10'h01A;

  // rate select register fields
  localparam int          RS_SWRST         = 7;
  localparam int          RS_LOWPWR        = 6;
  localparam int          RS_UNDEF         = 5;
  localparam int          RS_PC_LSB        = 2;
  localparam logic [7:0]  RS_RESET         = 8'h02;

  // main status fields
  localparam int          MS_REQ           = 7;
  localparam int          MS_DIR           = 6;
  localparam int          MS_NONDMA        = 5;
  localparam int          MS_BUSY          = 4;
  localparam int          MS_SEEK_B        = 1;
  localparam int          MS_SEEK_A        = 0;

  // drive cfg fields
  localparam int          DC_TYPE_LSB      = 0;
  localparam int          DC_RTYPE_LSB     = 2;
  localparam int          DC_COMPAT2       = 4;

  // rate select codes
  localparam logic [1:0]  SEL_1M           = 2'h3;
  localparam logic [1:0]  SEL_500          = 2'h0;
  localparam logic [1:0]  SEL_VAR          = 2'h1;
  localparam logic [1:0]  SEL_250          = 2'h2;

  // data rates in kbps
  localparam logic [11:0] KBPS_2000        = 12'h7D0;
  localparam logic [11:0] KBPS_1000        = 12'h3E8;
  localparam logic [11:0] KBPS_500         = 12'h1F4;
  localparam logic [11:0] KBPS_300         = 12'h12C;
  localparam logic [11:0] KBPS_250         = 12'h0FA;

  // precomp delays in units of 10 ps
  localparam logic [15:0] PC_DEF_2M        = 16'h0820;
  localparam logic [15:0] PC_DEF_1M        = 16'h1047;
  localparam logic [15:0] PC_DEF_LOW       = 16'h30D4;

  function automatic logic [11:0] fhsr_rate_kbps(input logic [1:0] sel,
                                                 input logic [1:0] rtype);
    case (sel)
      SEL_1M:  fhsr_rate_kbps = KBPS_1000;
      SEL_500: fhsr_rate_kbps = KBPS_500;
      SEL_250: fhsr_rate_kbps = KBPS_250;
      default: begin
        case (rtype)
          2'h1:    fhsr_rate_kbps = KBPS_500;
          2'h2:    fhsr_rate_kbps = KBPS_2000;
          default: fhsr_rate_kbps = KBPS_300;
        endcase
      end
    endcase
  endfunction

  function automatic logic [15:0] fhsr_precomp(input logic [2:0]  code,
                                               input logic [11:0] kbps);
    logic fast;
    fast = (kbps == KBPS_2000);
    case (code)
      3'h0: fhsr_precomp = fast ? PC_DEF_2M : (kbps == KBPS_1000) ? PC_DEF_1M : PC_DEF_LOW;
      3'h1: fhsr_precomp = fast ? 16'h0820 : 16'h1047;
      3'h2: fhsr_precomp = fast ? 16'h104A : 16'h208E;
      3'h3: fhsr_precomp = fast ? 16'h186A : 16'h30D4;
      3'h4: fhsr_precomp = fast ? 16'h208A : 16'h411B;
      3'h5: fhsr_precomp = fast ? 16'h28B4 : 16'h5161;
      3'h6: fhsr_precomp = fast ? 16'h30D4 : 16'h61A8;
      default: fhsr_precomp = 16'h0000;
    endcase
  endfunction

endpackage

/* verilog/fhsr_mem.sv */
`timescale 1ns/10ps
`default_nettype none

module fhsr_mem #(
  parameter int W     = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  input  wire logic          i_core_clk,
  input  wire logic          i_arst_n,
  input  wire logic          i_clk_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rdata;
  } fhsr_mem_st_t;

  fhsr_mem_st_t s_q;
  fhsr_mem_st_t s_d;

  // write-first read so a fresh head byte is seen at once
  always_comb begin
    s_d = s_q;
    if (i_we) begin
      s_d.mem[i_waddr] = i_wdata;
    end
    s_d.rdata = (i_we && (i_waddr == i_raddr)) ? i_wdata : s_q.mem[i_raddr];
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q <= '0;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  assign o_rdata = s_q.rdata;

endmodule

`default_nettype wire

/* verilog/fhsr_top.sv */
// Behaviour
// - rate select bit 6 without bit 7 enters low power
// - reset or port access leaves low power
// - bit 7 soft reset, self clearing
// - rate select writes copied to shadow
// - fixed rate and density per select code
// - select 01 rate follows drive rate type
// - rate outputs and density onto pins
// - drive type picks density pin mapping
// - default precomp delay per data rate
// - main status readable any time, after one apb wait cycle
// - seek bits follow drive seeking
// - busy bit follows command in progress
// - non dma bit reads zero
// - direction bit shows transfer direction while request bit set
// - request bit gates data port access
// - all bytes through one data port
// - fifo disabled after any reset
// - parameters unbuffered, fifo flushed at execution
// - overrun or underrun ends transfer, zero pad
// - digital input mode one, change bit
// - digital input mode two, rate bits
// - rate kept on soft, 250k on hard
// - density high at reset, soft-reset proof
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module fhsr_top #(
  parameter int DEPTH = 16
) (
  input  wire logic                        i_core_clk,
  input  wire logic                        i_arst_n,
  input  wire logic                        i_clk_en,
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [fhsr_pkg::APB_AW-1:0] i_paddr,
  input  wire logic [31:0]                 i_pwdata,
  output logic      [31:0]                 o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  input  wire logic                        i_drive_a_seeking,
  input  wire logic                        i_drive_b_seeking,
  input  wire logic                        i_cmd_busy,
  input  wire logic                        i_xfer_req,
  input  wire logic                        i_xfer_dir,
  input  wire logic                        i_exec_phase,
  input  wire logic                        i_cfg_load,
  input  wire logic                        i_cfg_fifo_en,
  input  wire logic [3:0]                  i_cfg_thresh,
  input  wire logic                        i_ctl_reset,
  input  wire logic                        i_core_push,
  input  wire logic [7:0]                  i_core_wdata,
  input  wire logic                        i_core_pop,
  input  wire logic                        i_disk_changed_flag_pin,
  output logic      [7:0]                  o_core_rdata,
  output logic                             o_core_rvalid,
  output logic                             o_xfer_error,
  output logic                             o_fifo_service,
  output logic                             o_low_power,
  output logic                             o_soft_reset,
  output logic      [1:0]                  o_rate_out,
  output logic                             o_density_select_out,
  output logic      [1:0]                  o_drive_density_pin,
  output logic      [11:0]                 o_rate_kbps,
  output logic      [15:0]                 o_precomp_delay
);
  import fhsr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [7:0]  rate_sel;
    logic [7:0]  shadow;
    logic        force_chg;
    logic [4:0]  drive_cfg;
    logic        low_pwr;
    logic        sw_rst;
    logic        fifo_en;
    logic [3:0]  thresh;
    logic        exec;
    logic        xfer_err;
    logic [AW:0] count;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  core_rdata;
    logic        core_rvalid;
    logic        service;
    logic        density;
    logic [1:0]  rate_o;
    logic [1:0]  pins;
    logic [11:0] kbps;
    logic [15:0] precomp;
  } fhsr_st_t;

  fhsr_st_t s_q;
  fhsr_st_t s_d;

  logic [IDX_W-1:0] idx;
  logic             start;
  logic             done;
  logic             wr;
  logic             rd;
  logic             any_rst;
  logic [AW:0]      cap;
  logic             full;
  logic             empty;
  logic             transfer_request_flag;
  logic [7:0]       main_status;
  logic [7:0]       dir_val;
  logic             chg;
  logic             host_push;
  logic             host_pop;
  logic             core_push;
  logic             core_pop;
  logic             push;
  logic             pop;
  logic [7:0]       mem_rdata;

  assign idx   = i_paddr[APB_AW-1:2];
  assign start = i_psel & i_penable & ~s_q.pready;
  assign done  = i_psel & i_penable & s_q.pready;
  assign wr    = done & i_pwrite;
  assign rd    = done & ~i_pwrite;
  assign any_rst = s_q.sw_rst | i_ctl_reset;

  assign cap   = (s_q.fifo_en & s_q.exec) ? (AW+1)'(DEPTH) : (AW+1)'(1);
  assign full  = (s_q.count >= cap);
  assign empty = (s_q.count == '0);
  // request only when a byte may move
  assign transfer_request_flag   = i_xfer_req & (i_xfer_dir ? ~empty : ~full);

  assign main_status = {transfer_request_flag, i_xfer_dir & transfer_request_flag, 1'b0, i_cmd_busy, 2'h0,
                i_drive_b_seeking, i_drive_a_seeking};

  assign chg = ~i_disk_changed_flag_pin | s_q.force_chg;
  assign dir_val = s_q.drive_cfg[DC_COMPAT2] ?
                   {chg, 4'hF, s_q.rate_sel[1:0],
                    (s_q.kbps == KBPS_250) | (s_q.kbps == KBPS_300)} :
                   {chg, 7'h00};

  assign host_push = wr & (idx == IDX_DATA_PORT) & ~i_xfer_dir & transfer_request_flag;
  assign host_pop  = rd & (idx == IDX_DATA_PORT) & i_xfer_dir & transfer_request_flag;
  assign core_push = i_core_push & i_xfer_dir & ~full;
  assign core_pop  = i_core_pop & ~i_xfer_dir & ~empty;
  assign push      = host_push | core_push;
  assign pop       = host_pop | core_pop;

  always_comb begin
    s_d = s_q;
    s_d.sw_rst      = 1'b0;
    s_d.core_rvalid = 1'b0;

    // apb: one wait cycle, answer registered
    if (start) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata  = 32'h0000_0000;
      case (idx)
        IDX_MAIN_STATUS: s_d.prdata = {24'h00_0000, main_status};
        IDX_DATA_PORT:   s_d.prdata = {24'h00_0000, (i_xfer_dir & transfer_request_flag) ? mem_rdata : 8'h00};
        IDX_DIGITAL_IN:  s_d.prdata = {24'h00_0000, dir_val};
        IDX_FORCE_CHG:   s_d.prdata = {31'h0000_0000, s_q.force_chg};
        IDX_RATE_SHADOW: s_d.prdata = {24'h00_0000, s_q.shadow};
        IDX_DRIVE_CFG:   s_d.prdata = {27'h000_0000, s_q.drive_cfg};
        default:         s_d.pslverr = 1'b1;
      endcase
    end else begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end

    if (wr && (idx == IDX_MAIN_STATUS)) begin
      s_d.rate_sel = {1'b0, i_pwdata[RS_LOWPWR], 1'b0, i_pwdata[4:0]};
      s_d.shadow   = i_pwdata[7:0];
      s_d.sw_rst   = i_pwdata[RS_SWRST];
      s_d.density  = (i_pwdata[1:0] == SEL_1M) | (i_pwdata[1:0] == SEL_500);
    end
    if (wr && (idx == IDX_FORCE_CHG)) begin
      s_d.force_chg = i_pwdata[0];
    end
    if (wr && (idx == IDX_DRIVE_CFG)) begin
      s_d.drive_cfg = i_pwdata[4:0];
    end

    if (any_rst || (done && (idx == IDX_DATA_PORT)) ||
        (rd && (idx == IDX_MAIN_STATUS))) begin
      s_d.low_pwr = 1'b0;
    end
    if (wr && (idx == IDX_MAIN_STATUS) && i_pwdata[RS_LOWPWR] && !i_pwdata[RS_SWRST]) begin
      s_d.low_pwr = 1'b1;
    end

    if (i_cfg_load) begin
      s_d.fifo_en = i_cfg_fifo_en;
      s_d.thresh  = i_cfg_thresh;
    end
    s_d.exec = i_exec_phase;

    // fifo pointers
    if (push) begin
      s_d.wr_ptr = s_q.wr_ptr + AW'(1);
    end
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + AW'(1);
    end
    s_d.count = s_q.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    if (i_core_pop && !i_xfer_dir) begin
      s_d.core_rvalid = 1'b1;
      s_d.core_rdata  = (empty || s_q.xfer_err) ? 8'h00 : mem_rdata;
    end

    if (i_exec_phase && !s_q.exec) begin
      s_d.count    = '0;
      s_d.wr_ptr   = '0;
      s_d.rd_ptr   = '0;
      s_d.xfer_err = 1'b0;
    end
    if (any_rst) begin
      s_d.fifo_en  = 1'b0;
      s_d.exec     = 1'b0;
      s_d.count    = '0;
      s_d.wr_ptr   = '0;
      s_d.rd_ptr   = '0;
      s_d.xfer_err = 1'b0;
    end
    if ((i_core_push && i_xfer_dir && full) || (i_core_pop && !i_xfer_dir && empty)) begin
      s_d.xfer_err = 1'b1;
    end

    s_d.service = s_q.fifo_en & s_q.exec &
                  (i_xfer_dir ? (s_q.count > {1'b0, s_q.thresh}) :
                                ((cap - s_q.count) > {1'b0, s_q.thresh}));

    // select 01 follows drive rate type
    s_d.kbps    = fhsr_rate_kbps(s_d.rate_sel[1:0], s_d.drive_cfg[DC_RTYPE_LSB +: 2]);
    s_d.precomp = fhsr_precomp(s_d.rate_sel[4:RS_PC_LSB], s_d.kbps);
    s_d.rate_o  = s_d.rate_sel[1:0];
    case (s_d.drive_cfg[DC_TYPE_LSB +: 2])
      2'h0:    s_d.pins = {s_d.rate_sel[0], s_d.density};
      2'h2:    s_d.pins = {s_d.rate_sel[0], s_d.rate_sel[1]};
      2'h1:    s_d.pins = {s_d.rate_sel[0], ~s_d.density};
      default: s_d.pins = {s_d.rate_sel[1], s_d.rate_sel[0]};
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_q          <= '0;
      s_q.rate_sel <= RS_RESET;
      s_q.shadow   <= RS_RESET;
      s_q.density  <= 1'b1;
      s_q.rate_o   <= RS_RESET[1:0];
      s_q.pins     <= {RS_RESET[0], 1'b1};
      s_q.kbps     <= KBPS_250;
      s_q.precomp  <= PC_DEF_LOW;
    end else if (i_clk_en) begin
      s_q <= s_d;
    end
  end

  fhsr_mem #(
    .W     (8),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_mem (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_we       (push),
    .i_waddr    (s_q.wr_ptr),
    .i_wdata    (host_push ? i_pwdata[7:0] : i_core_wdata),
    .i_raddr    (s_d.rd_ptr),
    .o_rdata    (mem_rdata)
  );

  assign o_prdata             = s_q.prdata;
  assign o_pready             = s_q.pready;
  assign o_pslverr            = s_q.pslverr;
  assign o_core_rdata         = s_q.core_rdata;
  assign o_core_rvalid        = s_q.core_rvalid;
  assign o_xfer_error         = s_q.xfer_err;
  assign o_fifo_service       = s_q.service;
  assign o_low_power          = s_q.low_pwr;
  assign o_soft_reset         = s_q.sw_rst;
  assign o_rate_out           = s_q.rate_o;
  assign o_density_select_out = s_q.density;
  assign o_drive_density_pin  = s_q.pins;
  assign o_rate_kbps          = s_q.kbps;
  assign o_precomp_delay      = s_q.precomp;

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  logic wr_rs;
  assign wr_rs = i_clk_en & wr & (idx == IDX_MAIN_STATUS);

  chk_lowpwr_enter: assert property (
    wr_rs && i_pwdata[RS_LOWPWR] && !i_pwdata[RS_SWRST] |=> o_low_power)
    else $error("low power not entered");
  chk_lowpwr_exit: assert property (
    i_clk_en && done && (idx == IDX_DATA_PORT) |=> !o_low_power)
    else $error("low power kept after data port access");
  chk_swrst_pulse: assert property (
    wr_rs && i_pwdata[RS_SWRST] |=> o_soft_reset ##1 (!o_soft_reset || $past(wr_rs)))
    else $error("soft reset not a single pulse");
  chk_shadow_copy: assert property (
    wr_rs |=> s_q.shadow == $past(i_pwdata[7:0]))
    else $error("shadow differs from written value");
  chk_rate_1m: assert property (
    wr_rs && (i_pwdata[1:0] == SEL_1M) |=> o_density_select_out && (o_rate_kbps == KBPS_1000))
    else $error("1M select wrong");
  chk_nondma_zero: assert property (
    o_pready && !o_pslverr && (idx == IDX_MAIN_STATUS) |-> !o_prdata[MS_NONDMA])
    else $error("non dma bit set");
  chk_rate_keep: assert property (
    i_clk_en && o_soft_reset && !wr_rs |=> $stable(o_rate_out) && $stable(o_density_select_out))
    else $error("soft reset changed rate");
  chk_flush_exec: assert property (
    i_clk_en && i_exec_phase && !s_q.exec && !push |=> s_q.count == '0)
    else $error("fifo not flushed at execution");
  chk_fifo_reset: assert property (
    i_clk_en && any_rst && !i_cfg_load |=> !s_q.fifo_en ##0 (s_q.count == '0))
    else $error("fifo not disabled by reset");
  chk_underrun_err: assert property (
    i_clk_en && i_core_pop && !i_xfer_dir && empty |=> o_xfer_error && (o_core_rdata == 8'h00))
    else $error("underrun not flagged");

  cov_soft_reset: cover property (wr_rs && i_pwdata[RS_SWRST]);
  cov_host_read: cover property (i_clk_en && host_pop);
  cov_fifo_full: cover property (s_q.fifo_en && s_q.exec && full);
  cov_low_power: cover property (o_low_power ##1 !o_low_power);

endmodule

`default_nettype wire

/* verif/fhsr_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module fhsr_core_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_burst_go,
  input  wire logic [4:0] i_burst_len,
  input  wire logic [7:0] i_burst_base,
  input  wire logic       i_pop_go,
  input  wire logic       i_core_rvalid,
  input  wire logic [7:0] i_core_rdata,
  output logic            o_core_push,
  output logic      [7:0] o_core_wdata,
  output logic            o_core_pop,
  output logic      [7:0] o_last_byte
);
  logic [4:0] left_q;
  logic [7:0] next_q;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      left_q      <= 5'h00;
      next_q      <= 8'h00;
      o_core_pop  <= 1'b0;
      o_last_byte <= 8'h00;
    end else begin
      if (i_burst_go) begin
        left_q <= i_burst_len;
        next_q <= i_burst_base;
      end else if (left_q != 5'h00) begin
        left_q <= left_q - 5'h01;
        next_q <= next_q + 8'h01;
      end
      o_core_pop <= i_pop_go;
      if (i_core_rvalid) begin
        o_last_byte <= i_core_rdata;
      end
    end
  end

  assign o_core_push  = (left_q != 5'h00);
  // idle data shows inverse, never a stale byte
  assign o_core_wdata = o_core_push ? next_q : ~next_q;
endmodule

`default_nettype wire

/* verif/test_floppy_host_status_rate_regs.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_floppy_host_status_rate_regs;
  import fhsr_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pslverr, pready, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic seek_a, seek_b, busy, xreq, xdir, exec, cfg_load, cfg_en, ctl_rst, dchg;
  logic [3:0] cfg_th;
  logic push, pop, rvalid, xerr, svc, lowp, srst, den;
  logic [7:0] wdat, rdat, last_byte, tmp, bbase;
  logic [1:0] rate, pins, ep, epin;
  logic [11:0] kbps, kb;
  logic [15:0] pc, epc;
  logic bgo, pop_go, eden, low, cen;
  logic [4:0] blen;
  int error_cnt, samples_checked, sr_cnt;

  fhsr_top #(.DEPTH(16)) u_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_clk_en(cen),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_drive_a_seeking(seek_a), .i_drive_b_seeking(seek_b), .i_cmd_busy(busy),
    .i_xfer_req(xreq), .i_xfer_dir(xdir), .i_exec_phase(exec), .i_cfg_load(cfg_load),
    .i_cfg_fifo_en(cfg_en), .i_cfg_thresh(cfg_th), .i_ctl_reset(ctl_rst),
    .i_core_push(push), .i_core_wdata(wdat), .i_core_pop(pop),
    .i_disk_changed_flag_pin(dchg), .o_core_rdata(rdat), .o_core_rvalid(rvalid),
    .o_xfer_error(xerr), .o_fifo_service(svc), .o_low_power(lowp), .o_soft_reset(srst),
    .o_rate_out(rate), .o_density_select_out(den), .o_drive_density_pin(pins),
    .o_rate_kbps(kbps), .o_precomp_delay(pc));

  fhsr_core_model u_core (.i_core_clk(clk), .i_arst_n(rst_n), .i_burst_go(bgo),
    .i_burst_len(blen), .i_burst_base(bbase), .i_pop_go(pop_go), .i_core_rvalid(rvalid),
    .i_core_rdata(rdat), .o_core_push(push), .o_core_wdata(wdat), .o_core_pop(pop),
    .o_last_byte(last_byte));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (srst === 1'b1) begin
      sr_cnt++;
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                     output logic [7:0] rd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] t;
    apb(1'b1, idx, d, t);
    tick(1);
  endtask

  task automatic rdc(input logic [9:0] idx, input logic [7:0] e);
    logic [7:0] t;
    apb(1'b0, idx, 8'h00, t);
    `CHK(t, e)
    tick(1);
  endtask

  task automatic burst(input logic [4:0] n, input logic [7:0] b);
    @(posedge clk);
    bgo <= 1'b1;
    blen <= n;
    bbase <= b;
    @(posedge clk);
    bgo <= 1'b0;
    tick(n + 2);
  endtask

  task automatic pop1();
    @(posedge clk);
    pop_go <= 1'b1;
    @(posedge clk);
    pop_go <= 1'b0;
    tick(3);
  endtask

  task automatic exec_rise();
    @(posedge clk);
    exec <= 1'b0;
    @(posedge clk);
    exec <= 1'b1;
    tick(2);
  endtask

  initial begin
    {psel, penable, pwrite, seek_a, seek_b, busy, xreq, xdir, exec} = 9'h000;
    {cfg_load, cfg_en, ctl_rst, bgo, pop_go, last_err} = 6'h00;
    {paddr, pwdata, cfg_th, blen, bbase} = 61'h0;
    dchg = 1'b1;
    cen = 1'b1;
    rst_n = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    sr_cnt = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK({rate, den, pins}, 5'h15)
    `CHK({kbps, pc}, {KBPS_250, PC_DEF_LOW})
    rdc(IDX_RATE_SHADOW, 8'h02);
    rdc(10'h100, 8'h00);
    `CHK(last_err, 1'b1)
    // every drive type and select code, rate types 0 to 2
    for (int dt = 0; dt < 4; dt++) begin
      for (int rt = 0; rt < 3; rt++) begin
        for (int s = 0; s < 4; s++) begin
          wr(IDX_DRIVE_CFG, {3'h0, 1'b1, 2'(rt), 2'(dt)});
          wr(IDX_MAIN_STATUS, 8'(s));
          eden = (s == 3 || s == 0);
          ep = 2'(s);
          kb = (s == 3) ? KBPS_1000 : (s == 0) ? KBPS_500 : (s == 2) ? KBPS_250 :
               (rt == 1) ? KBPS_500 : (rt == 2) ? KBPS_2000 : KBPS_300;
          epc = (kb == KBPS_2000) ? 16'h0820 : (kb == KBPS_1000) ? 16'h1047 : 16'h30D4;
          low = (kb == KBPS_250 || kb == KBPS_300);
          `CHK(rate, ep)
          `CHK({den, kbps}, {eden, kb})
          `CHK(pc, epc)
          epin = (dt == 0) ? {ep[0], eden} : (dt == 2) ? {ep[0], ep[1]} :
                 (dt == 1) ? {ep[0], ~eden} : ep;
          `CHK(pins, epin)
          rdc(IDX_DIGITAL_IN, {1'b0, 4'hF, ep[1], ep[0], low});
        end
      end
    end
    // programmed precomp codes below 2 Mbps
    wr(IDX_MAIN_STATUS, 8'h1A);
    `CHK(pc, 16'h61A8)
    wr(IDX_MAIN_STATUS, 8'h1E);
    `CHK(pc, 16'h0000)
    wr(IDX_DRIVE_CFG, 8'h00);
    @(posedge clk);
    dchg <= 1'b0;
    rdc(IDX_DIGITAL_IN, 8'h80);
    @(posedge clk);
    dchg <= 1'b1;
    rdc(IDX_DIGITAL_IN, 8'h00);
    wr(IDX_FORCE_CHG, 8'h01);
    rdc(IDX_DIGITAL_IN, 8'h80);
    wr(IDX_FORCE_CHG, 8'h00);
    // low power entry and exits, soft reset
    wr(IDX_MAIN_STATUS, 8'h42);
    `CHK(lowp, 1'b1)
    rdc(IDX_MAIN_STATUS, 8'h00);
    `CHK(lowp, 1'b0)
    wr(IDX_MAIN_STATUS, 8'h42);
    rdc(IDX_DATA_PORT, 8'h00);
    `CHK(lowp, 1'b0)
    wr(IDX_MAIN_STATUS, 8'h43);
    wr(IDX_MAIN_STATUS, 8'h83);
    `CHK({lowp, rate, den, sr_cnt}, {1'b0, 2'h3, 1'b1, 32'd1})
    rdc(IDX_RATE_SHADOW, 8'h83);
    // status flags and one-byte handshake
    @(posedge clk);
    {seek_a, seek_b, busy, xreq} <= 4'hF;
    rdc(IDX_MAIN_STATUS, 8'h93);
    wr(IDX_DATA_PORT, 8'h5A);
    rdc(IDX_MAIN_STATUS, 8'h13);
    wr(IDX_DATA_PORT, 8'h77);
    pop1();
    `CHK(last_byte, 8'h5A)
    @(posedge clk);
    xdir <= 1'b1;
    rdc(IDX_MAIN_STATUS, 8'h13);
    burst(5'd1, 8'h3C);
    rdc(IDX_MAIN_STATUS, 8'hD3);
    rdc(IDX_DATA_PORT, 8'h3C);
    rdc(IDX_MAIN_STATUS, 8'h13);
    // full fifo, overrun, flush, reset disables
    @(posedge clk);
    {cfg_load, cfg_en, cfg_th} <= 6'h33;
    @(posedge clk);
    cfg_load <= 1'b0;
    exec_rise();
    burst(5'd16, 8'h10);
    `CHK({xerr, svc}, 2'b01)
    rdc(IDX_DATA_PORT, 8'h10);
    rdc(IDX_DATA_PORT, 8'h11);
    burst(5'd3, 8'h40);
    `CHK(xerr, 1'b1)
    exec_rise();
    `CHK(xerr, 1'b0)
    rdc(IDX_MAIN_STATUS, 8'h13);
    @(posedge clk);
    ctl_rst <= 1'b1;
    @(posedge clk);
    ctl_rst <= 1'b0;
    tick(1);
    burst(5'd2, 8'h60);
    `CHK(xerr, 1'b1)
    @(posedge clk);
    xdir <= 1'b0;
    exec_rise();
    pop1();
    `CHK({xerr, last_byte}, 9'h100)
    // frozen clock enable hides an exec edge
    @(posedge clk);
    {cen, exec} <= 2'b00;
    @(posedge clk);
    exec <= 1'b1;
    tick(2);
    cen <= 1'b1;
    tick(2);
    `CHK(xerr, 1'b1)
    // hard reset restores rate
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK({rate, den, kbps}, {2'h2, 1'b1, KBPS_250})
    final_report();
  end
endmodule

`default_nettype wire
